// ### rtl/awe_defs.svh
// offsets, fields, reset values and timing counts of the wake event bank
// Behaviour
// - 8-bit RW key data port reaches the table entry chosen by the key index.
// - key data port lives in standby well, cleared by standby resume reset.
// - event status is read-only, battery reset only, bits 7-5 read zero.
// - status bit 4 latches a standby supply off/on transition, read clears it.
// - status bit 3 flags a thermal shutdown event, read clears it.
// - status bit 2 flags a panel switch input event, read clears it.
// - status bit 1 latches a mouse wake-up event, read clears it.
// - status bit 0 latches a keyboard wake-up event, read clears it.
// - power control is RW, battery reset to zero, bits 7, 1, 0 reserved.
// - bits 6-5 pick power-loss recovery: off, on, previous, user last state.
// - bit 4 enables standby gate output, reset by battery reset and main supply reset.
// - bit 3 selects keyboard wake: 0 programmed keys only, 1 any key.
// - bit 2 enables wake hunting, self-clears when a keyboard or mouse wake is captured.
// - hunting enable is cleared by host bus reset.
// - hunting in S1 with keyboard or mouse wake drives the supply switch.
// - key sets at 00-0E, 30-3E, 40-4E; incoming keys readable at 10-1E.
// - user recovery uses last-state flag: 0 turns on, 1 stays off.
`ifndef AWE_DEFS_SVH
`define AWE_DEFS_SVH
`define AWE_OFS_KEY_INDEX 8'hE1
`define AWE_OFS_KEY_DATA 8'hE2
`define AWE_OFS_STATUS 8'hE3
`define AWE_OFS_PWR_CTRL 8'hE4
`define AWE_OFS_IRQ_MASK 8'hF0
`define AWE_RST_BYTE 8'h00
`define AWE_STS_USED 8'h1F
`define AWE_PWR_USED 8'h7C
`define AWE_BIT_KEYS 0
`define AWE_BIT_POINTER 1
`define AWE_BIT_PANEL 2
`define AWE_BIT_THERMAL 3
`define AWE_BIT_STANDBY 4
`define AWE_BIT_HUNT 2
`define AWE_BIT_ANY_KEY 3
`define AWE_BIT_GATE 4
`define AWE_POS_RECOVERY 5
`define AWE_SET0_LO 8'h00
`define AWE_SET0_HI 8'h0E
`define AWE_RX_LO 8'h10
`define AWE_RX_HI 8'h1E
`define AWE_SET1_LO 8'h30
`define AWE_SET1_HI 8'h3E
`define AWE_SET2_LO 8'h40
`define AWE_SET2_HI 8'h4E
`define AWE_TABLE_DEPTH 80
`define AWE_CLK_NS 10
`define AWE_SWITCH_PULSE_NS 1000
`define AWE_SWITCH_PULSE_CYC (`AWE_SWITCH_PULSE_NS / `AWE_CLK_NS)
`endif

// ### rtl/awe_pkg.sv
// types of the wake event bank
package awe_pkg;
  typedef enum logic [1:0] {
    AWE_REC_OFF = 2'b00,
    AWE_REC_ON = 2'b01,
    AWE_REC_PREVIOUS = 2'b10,
    AWE_REC_USER = 2'b11
  } awe_recovery_t;
endpackage : awe_pkg

// ### rtl/awe_regs.sv
// wake key table port, wake event status and power recovery control
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "awe_defs.svh"
module awe_regs #(
  parameter int PULSE_CYC = `AWE_SWITCH_PULSE_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic standby_resume_reset_n,
  input wire logic host_bus_reset_n,
  input wire logic main_supply_reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic key_rx_valid,
  input wire logic [7:0] key_rx_data,
  input wire logic key_seq_match,
  input wire logic pointer_wake_evt,
  input wire logic keys_wake_en,
  input wire logic pointer_wake_en,
  input wire logic thermal_shutdown_evt,
  input wire logic panel_switch_input,
  input wire logic standby_supply_ok,
  input wire logic sleep_s1,
  input wire logic prior_state_on,
  input wire logic last_state_off,
  output logic standby_gate_output_n,
  output logic supply_switch_output_n,
  output logic recovery_power_on,
  output logic any_key_mode,
  output logic irq
);
  logic [7:0] key_table [0:`AWE_TABLE_DEPTH-1];
  logic [7:0] index_q;
  logic [3:0] rx_ptr_q;
  logic [4:0] status_q;
  logic [4:0] status_d;
  logic [4:0] mask_q;
  logic [1:0] recovery_q;
  logic any_key_q;
  logic gate_en_q;
  logic hunt_q;
  logic panel_q;
  logic standby_q;
  logic [7:0] rdata_q;
  logic [$clog2(PULSE_CYC+1)-1:0] pulse_q;

  // software may write only the three programmed key sets
  function automatic logic key_writable(input logic [7:0] idx);
    key_writable = (idx >= `AWE_SET0_LO && idx <= `AWE_SET0_HI) ||
                   (idx >= `AWE_SET1_LO && idx <= `AWE_SET1_HI) ||
                   (idx >= `AWE_SET2_LO && idx <= `AWE_SET2_HI);
  endfunction : key_writable

  function automatic logic key_readable(input logic [7:0] idx);
    key_readable = key_writable(idx) ||
                   (idx >= `AWE_RX_LO && idx <= `AWE_RX_HI);
  endfunction : key_readable

  wire sel_index = addr == `AWE_OFS_KEY_INDEX;
  wire sel_data = addr == `AWE_OFS_KEY_DATA;
  wire sel_status = addr == `AWE_OFS_STATUS;
  wire sel_pwr = addr == `AWE_OFS_PWR_CTRL;
  wire sel_mask = addr == `AWE_OFS_IRQ_MASK;
  wire table_wr = wr && sel_data && key_writable(index_q);
  wire [7:0] table_rd = key_readable(index_q) ?
                        key_table[index_q[6:0]] : `AWE_RST_BYTE;
  wire [7:0] rx_slot = `AWE_RX_LO + {4'h0, rx_ptr_q};

  // keyboard wake follows the selected criterion
  wire kb_wake = (any_key_q ? key_rx_valid : key_seq_match)
                 && keys_wake_en;
  wire ms_wake = pointer_wake_evt && pointer_wake_en;
  wire panel_evt = panel_switch_input && !panel_q;
  wire standby_evt = standby_supply_ok != standby_q;
  wire [4:0] events = {standby_evt, thermal_shutdown_evt, panel_evt,
                       ms_wake, kb_wake};
  wire status_clr = rd && sel_status;
  wire start_pulse = hunt_q && sleep_s1 && (kb_wake || ms_wake);

  // set wins over the clearing read so no event is dropped
  assign status_d = (status_clr ? 5'h00 : status_q) | events;

  wire [7:0] pwr_view = {1'b0, recovery_q, gate_en_q, any_key_q, hunt_q,
                         2'b00};
  wire [7:0] rd_mux = sel_index ? index_q :
                      sel_data ? table_rd :
                      sel_status ? {3'b000, status_q} :
                      sel_pwr ? pwr_view :
                      sel_mask ? {3'b000, mask_q} : `AWE_RST_BYTE;

  // the table sits in the standby well; a resume reset wipes it
  always_ff @(posedge mclk) begin
    if (!standby_resume_reset_n) begin
      for (int i = 0; i < `AWE_TABLE_DEPTH; i++) begin
        key_table[i] <= `AWE_RST_BYTE;
      end
    end else begin
      if (table_wr) begin
        key_table[index_q[6:0]] <= wdata;
      end
      if (key_rx_valid) begin
        key_table[rx_slot[6:0]] <= key_rx_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!standby_resume_reset_n) begin
      index_q <= `AWE_RST_BYTE;
      rx_ptr_q <= 4'h0;
    end else begin
      if (wr && sel_index) begin
        index_q <= wdata;
      end
      if (key_rx_valid) begin
        rx_ptr_q <= (rx_ptr_q == 4'hE) ? 4'h0 : rx_ptr_q + 4'h1;
      end
    end
  end

  // battery-backed flags; only the battery reset clears them
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= 5'h00;
      mask_q <= 5'h00;
      recovery_q <= 2'b00;
      any_key_q <= 1'b0;
      panel_q <= 1'b0;
      standby_q <= 1'b1;
    end else begin
      status_q <= status_d;
      panel_q <= panel_switch_input;
      standby_q <= standby_supply_ok;
      if (wr && sel_mask) begin
        mask_q <= wdata[4:0];
      end
      if (wr && sel_pwr) begin
        recovery_q <= wdata[`AWE_POS_RECOVERY +: 2];
        any_key_q <= wdata[`AWE_BIT_ANY_KEY];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gate_en_q <= 1'b0;
    end else if (!main_supply_reset_n) begin
      gate_en_q <= 1'b0;
    end else if (wr && sel_pwr) begin
      gate_en_q <= wdata[`AWE_BIT_GATE];
    end
  end

  // a captured wake ends hunting even against a same-cycle write
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hunt_q <= 1'b0;
    end else if (!host_bus_reset_n) begin
      hunt_q <= 1'b0;
    end else if (hunt_q && (kb_wake || ms_wake)) begin
      hunt_q <= 1'b0;
    end else if (wr && sel_pwr) begin
      hunt_q <= wdata[`AWE_BIT_HUNT];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_q <= '0;
    end else if (start_pulse) begin
      pulse_q <= ($clog2(PULSE_CYC+1))'(PULSE_CYC);
    end else if (pulse_q != '0) begin
      pulse_q <= pulse_q - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= `AWE_RST_BYTE;
    end else begin
      rdata_q <= rd ? rd_mux : `AWE_RST_BYTE;
    end
  end

  always_comb begin
    case (awe_pkg::awe_recovery_t'(recovery_q))
      awe_pkg::AWE_REC_OFF: recovery_power_on = 1'b0;
      awe_pkg::AWE_REC_ON: recovery_power_on = 1'b1;
      awe_pkg::AWE_REC_PREVIOUS: recovery_power_on = prior_state_on;
      awe_pkg::AWE_REC_USER: recovery_power_on = !last_state_off;
      default: recovery_power_on = 1'b0;
    endcase
  end

  assign rdata = rdata_q;
  assign standby_gate_output_n = !gate_en_q;
  assign supply_switch_output_n = !(pulse_q != '0);
  assign any_key_mode = any_key_q;
  assign irq = |(status_q & mask_q);
endmodule : awe_regs

// ### verif/awe_regs_chk.sv
// port assertions of the wake event register bank
`timescale 1ns/1ps
module awe_regs_chk #(
  parameter int PULSE_CYC = 4
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic pointer_wake_evt,
  input wire logic thermal_shutdown_evt,
  input wire logic standby_gate_output_n,
  input wire logic supply_switch_output_n,
  input wire logic recovery_power_on,
  input wire logic any_key_mode
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  wire wr_ctl = wr && addr == 8'hE4;
  wire rd_sts = rd && addr == 8'hE3;
  gate_enable_a: assert property (wr_ctl |=>
    standby_gate_output_n == !$past(wdata[4])) else $error("gate output");
  any_key_a: assert property (wr_ctl |=>
    any_key_mode == $past(wdata[3])) else $error("key wake mode");
  recovery_fixed_a: assert property (wr_ctl && !wdata[6] |=>
    recovery_power_on == $past(wdata[5])) else $error("recovery decode");
  ctrl_reserved_a: assert property (rd && addr == 8'hE4 |=>
    rdata[7] == 1'b0 && rdata[1:0] == 2'h0) else $error("ctrl reserved");
  sts_reserved_a: assert property (rd_sts |=>
    rdata[7:5] == 3'h0) else $error("status reserved");
  // the flag is visible one cycle after its event; skip a read in between
  thermal_flag_a: assert property (thermal_shutdown_evt ##1 !rd_sts
    ##1 rd_sts |=> rdata[3]) else $error("thermal flag lost");
  pointer_flag_a: assert property (pointer_wake_evt ##1 !rd_sts
    ##1 rd_sts |=> rdata[1]) else $error("pointer flag lost");
  // the pulse length is the bench value of PULSE_CYC
  switch_pulse_a: assert property ($fell(supply_switch_output_n) |->
    !supply_switch_output_n [*4] ##1 supply_switch_output_n)
    else $error("switch pulse length");
endmodule : awe_regs_chk
bind awe_regs awe_regs_chk #(.PULSE_CYC(PULSE_CYC)) i_awe_regs_chk (.*);

// ### verif/awe_regs_tb.sv
// self-checking bench of the wake event register bank
`timescale 1ns/1ps
module awe_regs_tb;
  logic mclk = 0, arst_n = 0, standby_resume_reset_n = 0, wr = 0, rd = 0;
  logic host_bus_reset_n = 0, main_supply_reset_n = 0, key_rx_valid = 0;
  logic key_seq_match = 0, pointer_wake_evt = 0, thermal_shutdown_evt = 0;
  logic keys_wake_en = 1, pointer_wake_en = 1, panel_switch_input = 0;
  logic standby_supply_ok = 1, sleep_s1 = 0, prior_state_on = 0;
  logic last_state_off = 0, standby_gate_output_n, supply_switch_output_n;
  logic recovery_power_on, any_key_mode, irq;
  logic [7:0] addr = 0, wdata = 0, key_rx_data = 0, rdata, v, k;
  logic [31:0] seed = 21;
  int failures = 0, tests_run = 0, cyc = 0, i;
  awe_regs #(.PULSE_CYC(4)) i_awe_regs (.*);
  always #5 mclk = ~mclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic exp_on(input logic [7:0] c);
    return c[6] ? (c[5] ? !last_state_off : prior_state_on) : c[5];
  endfunction : exp_on
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge mclk);
    wr <= 0;
  endtask : wreg
  task rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1;
    @(posedge mclk);
    rd <= 0;
    #1 chk(rdata, e);
  endtask : rreg
  // standby level flips so every standby call is a fresh off/on change
  task ev(input int b);
    @(posedge mclk);
    case (b)
      0: key_seq_match <= 1;
      1: pointer_wake_evt <= 1;
      2: panel_switch_input <= 1;
      3: thermal_shutdown_evt <= 1;
      default: standby_supply_ok <= ~standby_supply_ok;
    endcase
    @(posedge mclk);
    {key_seq_match, pointer_wake_evt, thermal_shutdown_evt} <= 3'h0;
    panel_switch_input <= 0;
  endtask : ev
  task end_of_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    {arst_n, standby_resume_reset_n} <= 2'h3;
    {host_bus_reset_n, main_supply_reset_n} <= 2'h3;
    rreg(8'hE2, 8'h00);
    rreg(8'hE4, 8'h00);
    chk(standby_gate_output_n, 1);
    wreg(8'hE3, 8'hFF);
    rreg(8'hE3, 8'h00);
    rreg(8'h55, 8'h00);
    $display("reset values done");
    for (i = 0; i < 12; i++) begin
      v = 8'(rnd());
      k = 8'(rnd() % 15) + (i % 3 == 0 ? 8'h00 : i % 3 == 1 ? 8'h30 : 8'h40);
      wreg(8'hE1, k);
      wreg(8'hE2, v);
      rreg(8'hE2, v);
    end
    wreg(8'hE1, 8'h20);
    wreg(8'hE2, 8'hAA);
    rreg(8'hE2, 8'h00);
    $display("key table done");
    for (i = 0; i < 8; i++) begin
      v = 8'(rnd());
      {last_state_off, prior_state_on} <= v[1:0];
      wreg(8'hE4, v);
      rreg(8'hE4, v & 8'h7C);
      chk(any_key_mode, v[3]);
      chk(standby_gate_output_n, !v[4]);
      chk(recovery_power_on, exp_on(v));
    end
    wreg(8'hE4, 8'h00);
    $display("power control done");
    wreg(8'hF0, 8'h1F);
    for (i = 0; i < 5; i++) begin
      ev(i);
      #1 chk(irq, 1);
      rreg(8'hE3, 8'h01 << i);
      chk(irq, 0);
      rreg(8'hE3, 8'h00);
    end
    wreg(8'hF0, 8'h00);
    ev(3);
    #1 chk(irq, 0);
    @(posedge mclk);
    addr <= 8'hE3;
    rd <= 1;
    thermal_shutdown_evt <= 1;
    @(posedge mclk);
    {rd, thermal_shutdown_evt} <= 2'h0;
    #1 chk(rdata, 8'h08);
    rreg(8'hE3, 8'h08);
    wreg(8'hE4, 8'h08);
    wreg(8'hE1, 8'h10);
    @(posedge mclk);
    {key_rx_data, key_rx_valid} <= {8'h5A, 1'b1};
    @(posedge mclk);
    key_rx_valid <= 0;
    rreg(8'hE3, 8'h01);
    rreg(8'hE2, 8'h5A);
    $display("events done");
    sleep_s1 <= 1;
    wreg(8'hE4, 8'h04);
    ev(1);
    #1 chk(supply_switch_output_n, 0);
    rreg(8'hE4, 8'h00);
    rreg(8'hE3, 8'h02);
    chk(supply_switch_output_n, 1);
    sleep_s1 <= 0;
    wreg(8'hE4, 8'h14);
    @(posedge mclk) host_bus_reset_n <= 0;
    @(posedge mclk) host_bus_reset_n <= 1;
    rreg(8'hE4, 8'h10);
    @(posedge mclk) main_supply_reset_n <= 0;
    @(posedge mclk) main_supply_reset_n <= 1;
    rreg(8'hE4, 8'h00);
    wreg(8'hE1, 8'h00);
    wreg(8'hE2, 8'hAA);
    rreg(8'hE2, 8'hAA);
    @(posedge mclk) standby_resume_reset_n <= 0;
    @(posedge mclk) standby_resume_reset_n <= 1;
    rreg(8'hE2, 8'h00);
    $display("hunting and resets done");
    end_of_test();
  end
endmodule : awe_regs_tb
